/* File: src/wake_map.svh */
`ifndef WAKE_MAP_SVH
`define WAKE_MAP_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define WAKE_ENABLE_IDX 8'h2A
`define WAKE_STATUS_IDX 8'h6C
`define WAKE_PAT_BASE_IDX 8'h30
`define WAKE_PAT_LAST_IDX 8'h6B
// index step between patterns
`define WAKE_PAT_STRIDE 8'h10
// field index (index low nibble divided by two) inside a pattern block
`define WAKE_FLD_CRC_LOW 3'd0
`define WAKE_FLD_CRC_HIGH 3'd1
`define WAKE_FLD_MASK_FIRST 3'd2
`define WAKE_FLD_MASK_SECOND 3'd3
`define WAKE_FLD_MASK_THIRD 3'd4
`define WAKE_FLD_MASK_FOURTH 3'd5
`define WAKE_FLD_COUNT 6
// printed offsets of the pattern 1 to 3 registers, kept as indices
`define WAKE1_MASK_BYTES33_48_IDX 8'h48
`define WAKE1_MASK_BYTES49_64_IDX 8'h4A
`define WAKE2_CRC_LOW_IDX 8'h50
`define WAKE2_CRC_HIGH_IDX 8'h52
`define WAKE2_MASK_BYTES1_16_IDX 8'h54
`define WAKE2_MASK_BYTES17_32_IDX 8'h56
`define WAKE2_MASK_BYTES33_48_IDX 8'h58
`define WAKE2_MASK_BYTES49_64_IDX 8'h5A
`define WAKE3_CRC_LOW_IDX 8'h60
`define WAKE3_CRC_HIGH_IDX 8'h62
`define WAKE3_MASK_BYTES1_16_IDX 8'h64
`define WAKE3_MASK_BYTES17_32_IDX 8'h66
`define WAKE3_MASK_BYTES33_48_IDX 8'h68

// =====================================================================
// reset values and frame constants
`define WAKE_REG_RESET 16'h0000
`define WAKE_ENABLE_RESET 4'h0
`define WAKE_CRC_INIT 32'hFFFFFFFF
`define WAKE_CRC_POLY 32'hEDB88320
`define WAKE_WINDOW_BYTES 7'h40

`endif

/* File: src/wake_pkg.sv */
package wake_pkg;

   // =====================================================================
   // types shared by the matcher
   localparam int PATTERNS = 4;

   typedef logic [15:0] half_t;

   // one received frame byte from the receive path
   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic [7:0] data;
   } frm_s;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_FRAME = 2'b10
   } rx_state_e;

endpackage

/* File: src/wakeup_frame_pattern_match.sv */
// Contract
// (R1) each pattern runs an Ethernet CRC-32 over only the received bytes its mask selects.
// (R2) the expected CRC sits in two 16-bit registers, low half first, high half second.
// (R3) first mask register bit 0 selects byte 1 and bit 15 selects byte 16.
// (R4) second mask register bit 0 selects byte 17 and bit 15 selects byte 32.
// (R5) third mask register bit 0 selects byte 33 and bit 15 selects byte 48.
// (R6) fourth mask register bit 0 selects byte 49 and bit 15 byte 64, the last byte looked at.
// (R7) every CRC and mask register is 16-bit read/write and clears to zero on reset.
// (R8) each pattern is detected only while its own enable bit is set.
// (R9) a match is flagged at frame end when an enabled pattern's CRC equals its expected value.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wake_map.svh"

module wakeup_frame_pattern_match (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire wake_pkg::apb_req_s APB_REQ,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire wake_pkg::frm_s FRAME,
   output logic [3:0] WAKE_MATCH,
   output logic WAKE_DETECTED
);
   import wake_pkg::*;

   // =====================================================================
   // register storage
   half_t pat_reg [PATTERNS][`WAKE_FLD_COUNT];
   logic [3:0] detect_enable;
   logic [3:0] match_status;

   // =====================================================================
   // apb decode
   logic [7:0] reg_idx;
   logic [7:0] pat_off;
   logic [1:0] pat_sel;
   logic [2:0] fld_sel;
   logic pat_hit;
   logic access;
   logic wr_en;
   logic rd_en;
   logic mapped;

   // index split into pattern and field
   always_comb begin
      reg_idx = APB_REQ.paddr[9:2];
      pat_off = reg_idx - `WAKE_PAT_BASE_IDX;
      pat_sel = pat_off[5:4];
      fld_sel = pat_off[3:1];
      pat_hit = (reg_idx >= `WAKE_PAT_BASE_IDX) && (reg_idx <= `WAKE_PAT_LAST_IDX)
         && !pat_off[0] && (fld_sel <= `WAKE_FLD_MASK_FOURTH)
         && (APB_REQ.paddr[1:0] == 2'b00) && (APB_REQ.paddr[11:10] == 2'b00);
      mapped = pat_hit
         || (APB_REQ.paddr == {2'b00, `WAKE_ENABLE_IDX, 2'b00})
         || (APB_REQ.paddr == {2'b00, `WAKE_STATUS_IDX, 2'b00});
      access = CE && APB_REQ.psel && APB_REQ.penable && !PREADY;
      wr_en = access && APB_REQ.pwrite;
      rd_en = access && !APB_REQ.pwrite;
   end

   // one wait state, then pready for a single cycle
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         PREADY <= access;
         PSLVERR <= access && !mapped;
      end
   end

   // =====================================================================
   // read data source for the addressed register
   logic [31:0] next_prdata;

   // unmapped or reserved words read as zero
   always_comb begin
      next_prdata = 32'h00000000;
      if (pat_hit) begin
         case (fld_sel)
            `WAKE_FLD_CRC_LOW: begin
               next_prdata = {16'h0000, pat_reg[pat_sel][`WAKE_FLD_CRC_LOW]}; // R2
            end
            `WAKE_FLD_CRC_HIGH: begin
               next_prdata = {16'h0000, pat_reg[pat_sel][`WAKE_FLD_CRC_HIGH]}; // R2
            end
            `WAKE_FLD_MASK_FIRST: begin
               next_prdata = {16'h0000, pat_reg[pat_sel][`WAKE_FLD_MASK_FIRST]}; // R3
            end
            `WAKE_FLD_MASK_SECOND: begin
               next_prdata = {16'h0000, pat_reg[pat_sel][`WAKE_FLD_MASK_SECOND]}; // R4
            end
            `WAKE_FLD_MASK_THIRD: begin
               next_prdata = {16'h0000, pat_reg[pat_sel][`WAKE_FLD_MASK_THIRD]}; // R5
            end
            `WAKE_FLD_MASK_FOURTH: begin
               next_prdata = {16'h0000, pat_reg[pat_sel][`WAKE_FLD_MASK_FOURTH]}; // R6
            end
            default: begin
               next_prdata = 32'h00000000;
            end
         endcase
      end else if (mapped && reg_idx == `WAKE_ENABLE_IDX) begin
         next_prdata = {28'h0000000, detect_enable};
      end else if (mapped && reg_idx == `WAKE_STATUS_IDX) begin
         next_prdata = {28'h0000000, match_status};
      end
   end

   // read data captured with pready, held until the next read
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         PRDATA <= 32'h00000000;
      end else if (rd_en) begin
         PRDATA <= next_prdata;
      end
   end

   // pattern registers, written in the access cycle that raises pready
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         for (int p = 0; p < PATTERNS; p++) begin
            for (int f = 0; f < `WAKE_FLD_COUNT; f++) begin
               pat_reg[p][f] <= `WAKE_REG_RESET; // R7
            end
         end
      end else if (wr_en && pat_hit) begin
         pat_reg[pat_sel][fld_sel] <= APB_REQ.pwdata[15:0]; // R7
      end
   end

   // per-pattern detection enables
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         detect_enable <= `WAKE_ENABLE_RESET;
      end else if (wr_en && mapped && reg_idx == `WAKE_ENABLE_IDX) begin
         detect_enable <= APB_REQ.pwdata[3:0];
      end
   end

   // =====================================================================
   // frame tracking
   rx_state_e state;
   rx_state_e next_state;
   logic [6:0] byte_cnt;
   logic frame_byte;
   logic first_byte;

   always_comb begin
      frame_byte = CE && FRAME.valid && (FRAME.sof || state == ST_FRAME);
      first_byte = CE && FRAME.valid && FRAME.sof;
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (first_byte && !FRAME.eof) begin
               next_state = ST_FRAME;
            end
         end
         ST_FRAME: begin
            // any frame byte that also carries eof closes the frame at once
            if (frame_byte && FRAME.eof) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // receive state
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         state <= ST_IDLE;
      end else if (CE) begin
         state <= next_state;
      end
   end

   // byte position in the frame, saturating past the mask window
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         byte_cnt <= 7'h00;
      end else if (first_byte) begin
         byte_cnt <= 7'h01;
      end else if (frame_byte && byte_cnt < `WAKE_WINDOW_BYTES) begin
         byte_cnt <= byte_cnt + 7'h01;
      end
   end

   // one reflected crc-32 byte step
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int b = 0; b < 8; b++) begin
         r = (r[0] ^ d[b]) ? ((r >> 1) ^ `WAKE_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // =====================================================================
   // per-pattern crc and compare
   logic [3:0] frame_hit;
   logic [6:0] pos;

   // position of the current byte, zero based
   always_comb begin
      pos = first_byte ? 7'h00 : byte_cnt;
   end

   genvar g;
   generate
      for (g = 0; g < PATTERNS; g++) begin : gen_pat
         logic [15:0] mask_word;
         logic [31:0] crc;
         logic [31:0] crc_now;
         logic take;

         // mask word by quarter of the window, bit by byte inside it
         always_comb begin
            case (pos[5:4])
               2'b00: begin
                  mask_word = pat_reg[g][`WAKE_FLD_MASK_FIRST]; // R3
               end
               2'b01: begin
                  mask_word = pat_reg[g][`WAKE_FLD_MASK_SECOND]; // R4
               end
               2'b10: begin
                  mask_word = pat_reg[g][`WAKE_FLD_MASK_THIRD]; // R5
               end
               2'b11: begin
                  mask_word = pat_reg[g][`WAKE_FLD_MASK_FOURTH]; // R6
               end
               default: begin
                  mask_word = 16'h0000;
               end
            endcase
         end

         // bytes past the window never reach the crc
         always_comb begin
            take = frame_byte && pos < `WAKE_WINDOW_BYTES && mask_word[pos[3:0]]; // R1
            crc_now = first_byte ? `WAKE_CRC_INIT : crc;
            if (take) begin
               crc_now = crc_step(crc_now, FRAME.data); // R1
            end
            frame_hit[g] = frame_byte && FRAME.eof && detect_enable[g] // R8
               && (~crc_now == {pat_reg[g][`WAKE_FLD_CRC_HIGH], // R2
                  pat_reg[g][`WAKE_FLD_CRC_LOW]}); // R9
         end

         // running crc, restarted by each frame start
         always_ff @(posedge MCLK) begin
            if (SYS_RST) begin
               crc <= `WAKE_CRC_INIT;
            end else if (frame_byte) begin
               crc <= crc_now;
            end
         end
      end
   endgenerate

   // match pulses and summary, registered
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         WAKE_MATCH <= 4'h0;
         WAKE_DETECTED <= 1'b0;
      end else if (CE) begin
         WAKE_MATCH <= frame_hit; // R9
         WAKE_DETECTED <= |frame_hit;
      end
   end

   // =====================================================================
   // sticky match flags, write one to clear, a new match wins
   logic [3:0] next_match_status;
   logic status_write;

   // clear first, then set, so a match in the clearing cycle survives
   always_comb begin
      status_write = wr_en && mapped && reg_idx == `WAKE_STATUS_IDX;
      next_match_status = match_status;
      if (status_write) begin
         next_match_status = match_status & ~APB_REQ.pwdata[3:0];
      end
      next_match_status = next_match_status | frame_hit; // R9
   end

   // status register
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         match_status <= 4'h0;
      end else if (CE) begin
         match_status <= next_match_status;
      end
   end

endmodule

`default_nettype wire

/* File: sim/wake_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// port checks of the matcher
module wake_assertions (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire wake_pkg::apb_req_s APB_REQ,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire wake_pkg::frm_s FRAME,
   input wire logic [3:0] WAKE_MATCH,
   input wire logic WAKE_DETECTED
);
   import wake_pkg::*;
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   // bus answer
   chk_ready_wait: assert property (
      APB_REQ.psel && APB_REQ.penable && CE && !PREADY |=> PREADY) else $error("no ready");
   chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("long ready");
   chk_err_ready: assert property (PSLVERR |-> PREADY) else $error("lone error");
   chk_rdata_hold: assert property (
      $changed(PRDATA) |-> (PREADY && !APB_REQ.pwrite) || $past(SYS_RST))
      else $error("read data moved");
   chk_upper_zero: assert property (
      PREADY |-> PRDATA[31:16] == 16'h0000) else $error("upper bits set");
   chk_reset_clear: assert property (
      $fell(SYS_RST) |-> !PREADY && PRDATA == 32'h0 && WAKE_MATCH == 4'h0) else $error("reset");
   // match outputs
   chk_any_match: assert property (WAKE_DETECTED == |WAKE_MATCH) else $error("detect");
   chk_match_eof: assert property (
      |WAKE_MATCH |-> $past(FRAME.valid) && $past(FRAME.eof)) else $error("stray match");
   cover property (|WAKE_MATCH);
   cover property (PSLVERR);
   cover property (PREADY && !APB_REQ.pwrite);
endmodule
bind wakeup_frame_pattern_match wake_assertions i_wake_assertions (.MCLK(MCLK), .SYS_RST(SYS_RST),
   .CE(CE), .APB_REQ(APB_REQ), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .FRAME(FRAME), .WAKE_MATCH(WAKE_MATCH), .WAKE_DETECTED(WAKE_DETECTED));
`default_nettype wire

/* File: sim/rx_source.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// receive path model, prompt or with idle gaps
module rx_source (
   input wire logic MCLK,
   output var wake_pkg::frm_s FRAME
);
   import wake_pkg::*;
   logic [7:0] mem [0:79];
   initial FRAME = '0;
   // idle data lines show the inverse of the last byte
   task automatic send(input int n, input bit slow);
      for (int k = 0; k < n; k++) begin
         @(posedge MCLK);
         FRAME <= '{1'b1, k == 0, k == n - 1, mem[k]};
         if (slow) begin
            @(posedge MCLK);
            FRAME <= '{1'b0, 1'b0, 1'b0, ~mem[k]};
         end
      end
      @(posedge MCLK);
      FRAME <= '{1'b0, 1'b0, 1'b0, ~mem[n - 1]};
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_wakeup_frame_pattern_match.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// bench for the wake-up pattern matcher
module tb_wakeup_frame_pattern_match;
   import wake_pkg::*;
   logic MCLK, SYS_RST, CE, PREADY, PSLVERR, WAKE_DETECTED, e, dseen;
   apb_req_s req;
   frm_s frm;
   logic [31:0] PRDATA, q, d;
   logic [3:0] WAKE_MATCH, seen;
   logic [31:0] crc [0:3];
   logic [63:0] msk [0:3];
   int mismatches, samples_checked, cyc;
   wakeup_frame_pattern_match i_wakeup_frame_pattern_match (.MCLK(MCLK), .SYS_RST(SYS_RST),
      .CE(CE), .APB_REQ(req), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .FRAME(frm), .WAKE_MATCH(WAKE_MATCH), .WAKE_DETECTED(WAKE_DETECTED));
   rx_source i_rx_source (.MCLK(MCLK), .FRAME(frm));
   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end
   // sticky match record and watchdog
   always @(posedge MCLK) begin
      seen = seen | WAKE_MATCH;
      dseen = dseen | WAKE_DETECTED;
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         report_and_stop;
      end
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge MCLK);
      req <= '{1'b1, 1'b0, w, a, wd};
      @(posedge MCLK);
      req.penable <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      req <= '0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic er);
      apb(1'b0, a, 32'h0);
      check(q, x);
      check({31'h0, e}, {31'h0, er});
   endtask
   function automatic logic [11:0] ad(input int p, input int f);
      return 12'((32'h30 + 32'h10 * p + 32'h2 * f) * 32'h4);
   endfunction
   // reference crc over masked bytes of the first 64
   function automatic logic [31:0] fcs(input logic [63:0] m, input int n);
      logic [31:0] c;
      c = 32'hFFFFFFFF;
      for (int k = 0; k < n && k < 64; k++)
         if (m[k]) begin
            c = c ^ {24'h000000, i_rx_source.mem[k]};
            for (int b = 0; b < 8; b++)
               c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
         end
      return ~c;
   endfunction
   task automatic frame(input int n, input bit slow, input logic [3:0] en);
      logic [3:0] x;
      for (int p = 0; p < 4; p++)
         x[p] = en[p] && fcs(msk[p], n) == crc[p];
      apb(1'b1, 12'h0A8, {28'h0, en});
      seen = 4'h0;
      dseen = 1'b0;
      i_rx_source.send(n, slow);
      repeat (2) @(posedge MCLK);
      check({28'h0, seen}, {28'h0, x});
      check({31'h0, dseen}, {31'h0, |x});
      rd(12'h1B0, {28'h0, x}, 1'b0);
      apb(1'b1, 12'h1B0, 32'h0000000F);
   endtask
   // main sequence
   initial begin
      SYS_RST = 1'b1;
      CE = 1'b1;
      req = '0;
      seen = 4'h0;
      dseen = 1'b0;
      mismatches = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (6) @(posedge MCLK);
      SYS_RST <= 1'b0;
      for (int p = 1; p < 4; p++)
         for (int f = 0; f < 6; f++)
            rd(ad(p, f), 32'h0, 1'b0);
      rd(12'h130, 32'h0, 1'b1);
      for (int k = 0; k < 80; k++)
         i_rx_source.mem[k] = 8'(k * 37 + 5);
      msk[0] = 64'h0;
      crc[0] = 32'h0;
      msk[1] = 64'h8001_8000_0001_8001;
      msk[2] = 64'h0100_0010_7FFE_0002;
      msk[3] = 64'h0000_FFFF_0000_0C30;
      for (int p = 1; p < 4; p++) begin
         crc[p] = fcs(msk[p], 70) ^ (p == 2 ? 32'h1 : 32'h0);
         for (int f = 0; f < 6; f++) begin
            d = f < 2 ? {16'h0000, crc[p][16 * f +: 16]} : {16'h0000, msk[p][16 * f - 32 +: 16]};
            apb(1'b1, ad(p, f), d);
            rd(ad(p, f), d, 1'b0);
         end
      end
      frame(70, 1'b0, 4'h6);
      frame(70, 1'b1, 4'hF);
      frame(40, 1'b0, 4'hF);
      frame(1, 1'b0, 4'hF);
      CE <= 1'b0;
      seen = 4'h0;
      i_rx_source.send(1, 1'b0);
      CE <= 1'b1;
      repeat (2) @(posedge MCLK);
      check({28'h0, seen}, 32'h0);
      frame(70, 1'b0, 4'h0);
      apb(1'b1, 12'h0A8, 32'h0000000F);
      rd(12'h0A8, 32'h0000000F, 1'b0);
      @(posedge MCLK);
      SYS_RST <= 1'b1;
      repeat (2) @(posedge MCLK);
      SYS_RST <= 1'b0;
      rd(ad(2, 0), 32'h0, 1'b0);
      rd(12'h0A8, 32'h0, 1'b0);
      report_and_stop;
   end
endmodule
`default_nettype wire
